// file: core/wrs_pkg.sv
/*
 * Constants shared by the guard timer and reset-status block: register indices,
 * bit positions, reset values and counts.
 * Assumes an Avalon-MM master that addresses bytes, one 32-bit word per register.
 */
//
// Summary of operation
// - Timeout counter counts ticks of its own 125 kHz oscillator, not the system clock.
// - Counter reaching the selected timeout raises interrupt or system reset per mode.
// - Restart instruction zeroes the counter; software must restart it before timeout.
// - Interrupt-only mode raises interrupt without reset; interrupt can wake from sleep.
// - System-reset mode resets the device on expiry.
// - Combined mode interrupts first, then drops to reset mode for the next expiry.
// - Programmed always-on fuse forces reset mode: reset enable 1, irq enable 0.
// - New reset enable and prescale, change enable clear, accepted only within four cycles.
// - After a guard reset the timer stays enabled until software disables it.
// - Reset-status register holds five source flags in bits 4..0; top three read-only.
// - Scan reset flag sets on scan-chain reset; clears on power-on or writing zero.
// - Guard reset flag sets on guard reset; clears on power-on or writing zero.
// - Brown-out flag sets on brown-out reset; clears on power-on or writing zero.
// - Pin reset flag sets on external reset; clears on power-on or writing zero.
// - Power-on flag sets on power-on reset; clears only by writing zero.
// - Supply-low flag in bit 7 is set by hardware, cleared by power-on or by software writing one.
// - Supply-low interrupt requested only with flag, enable bit 6 and global enable.
// - Bit 0 switches supply monitoring on; bits 5..1 read as zero.
// - Hardware clears change enable four clock cycles after it is written to one.
// - Reset enable reads one and cannot clear while the guard reset flag is set.
// - Prescale code n gives 2048 shl n oscillator ticks, up to code 9; above reserved.
// - Vectoring clears guard irq flag and irq enable; writing one also clears the flag.
package wrs_pkg;
	// Register indices; the byte address is four times the index.
	localparam logic [7:0] IDX_RESET_SOURCE_FLAGS = 8'h34;
	localparam logic [7:0] IDX_GUARD_CONTROL_REG = 8'h60;
	localparam logic [7:0] IDX_SUPPLY_MONITOR_CONTROL = 8'h63;
	localparam int ADDR_W = 10;
	// Guard control register bit positions.
	localparam int BIT_IRQ_FLAG = 7;
	localparam int BIT_IRQ_ENABLE = 6;
	localparam int BIT_PRESCALE_HI = 5;
	localparam int BIT_CHANGE_ENABLE = 4;
	localparam int BIT_RESET_ENABLE = 3;
	// Reset-source flag positions.
	localparam int BIT_SCAN_FLAG = 4;
	localparam int BIT_GUARD_FLAG = 3;
	localparam int BIT_BROWNOUT_FLAG = 2;
	localparam int BIT_PIN_FLAG = 1;
	localparam int BIT_POWERON_FLAG = 0;
	// Supply monitor control bit positions.
	localparam int BIT_SUPPLY_LOW_FLAG = 7;
	localparam int BIT_SUPPLY_LOW_IE = 6;
	localparam int BIT_SUPPLY_ON = 0;
	// Power-on value of the reset-source flags: only the power-on flag set.
	localparam logic [4:0] RESET_FLAGS_INIT = 5'h01;
	// Guard oscillator nominal rate and timeout table.
	localparam int GUARD_OSC_KHZ = 125;
	localparam int TIMEOUT_BASE_TICKS = 2048;
	localparam logic [3:0] PRESCALE_MAX = 4'h9;
	// Change window length in system clock cycles.
	localparam logic [2:0] CHANGE_WIN_CYCLES = 3'h4;
endpackage

// file: core/wrs_guard.sv
/*
 * Guard timer with three timeout modes, fuse-forced reset mode and a timed change
 * window, plus the reset-source flags and the supply monitor control register,
 * all reached over an Avalon-MM slave with waitrequest.
 * Assumes all inputs are synchronous to clk_sys, that rstn is the power-on reset,
 * and that this block itself is not reset by the system reset it issues.
 */
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ns
module wrs_guard import wrs_pkg::*; #(
	parameter int CNT_W = 20
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic guard_osc,
	input wire logic guard_restart,
	input wire logic guard_vector_ack,
	input wire logic guard_always_on_fuse,
	input wire logic global_irq_enable,
	input wire logic scan_reset_event,
	input wire logic brownout_reset_event,
	input wire logic pin_reset_event,
	input wire logic supply_below,
	output logic guard_irq,
	output logic guard_sys_reset,
	output logic supply_monitor_on,
	output logic supply_low_irq
);

	////////////////////////////////////////////////////////////////////////////
	// Elaboration check: the counter must hold the longest timeout.
	if (CNT_W < 20 || CNT_W > 31) begin : g_bad_width
		$error("CNT_W must lie between 20 and 31.");
	end

	////////////////////////////////////////////////////////////////////////////
	// All state of the block in one record.
	typedef struct packed {
		logic osc_q;
		logic [CNT_W-1:0] count;
		logic [3:0] guard_prescale;
		logic guard_reset_enable;
		logic guard_irq_enable;
		logic guard_irq_flag;
		logic [2:0] win;
		logic [4:0] reset_source_flags;
		logic sys_reset;
		logic supply_low_flag;
		logic supply_low_irq_enable;
		logic supply_monitor_on;
		logic ack;
		logic [31:0] rdata;
	} wrs_state_type;

	wrs_state_type s;
	wrs_state_type next_s;

	// Byte-address match for a register index; used by both read and write decode.
	function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
		hit = (addr == ADDR_W'({idx, 2'b00}));
	endfunction

	logic tick;
	logic eff_re;
	logic eff_ie;
	logic running;
	logic [3:0] pre_eff;
	logic [CNT_W-1:0] limit;
	logic expire;
	logic do_irq;
	logic do_reset;
	logic wr_en;
	logic open_req;
	logic [7:0] wd;
	logic [7:0] ctrl_view;

	////////////////////////////////////////////////////////////////////////////
	// Mode decode and the timeout compare.
	always_comb begin
		// Guard oscillator is sampled as a plain level; a rising edge is one tick.
		tick = guard_osc & ~s.osc_q;
		// The fuse and a pending guard reset flag both pin reset enable high.
		eff_re = s.guard_reset_enable | guard_always_on_fuse
			| s.reset_source_flags[BIT_GUARD_FLAG];
		eff_ie = s.guard_irq_enable & ~guard_always_on_fuse;
		running = eff_re | eff_ie;
		// Reserved codes behave as the longest period rather than wrapping short.
		pre_eff = (s.guard_prescale > PRESCALE_MAX) ? PRESCALE_MAX : s.guard_prescale;
		// At code nine the base shifted into a 20-bit count wraps to zero; the minus
		// one below then yields all ones, which is still the correct last count.
		limit = CNT_W'(TIMEOUT_BASE_TICKS) << pre_eff;
		expire = running & tick & (s.count == limit - CNT_W'(1));
		// First expiry with the flag clear interrupts; in combined mode a later
		// expiry with the flag still pending resets instead.
		do_irq = expire & eff_ie & (~s.guard_irq_flag | ~eff_re);
		do_reset = expire & eff_re & ~do_irq;
		wr_en = avs_write & s.ack & avs_byteenable[0];
		wd = avs_writedata[7:0];
		open_req = wr_en & hit(avs_address, IDX_GUARD_CONTROL_REG)
			& wd[BIT_CHANGE_ENABLE] & wd[BIT_RESET_ENABLE];
		ctrl_view = {s.guard_irq_flag, eff_ie, s.guard_prescale[3], (s.win != 3'h0),
			eff_re, s.guard_prescale[2:0]};
	end

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic: counter, change window, bus accesses, then hardware sets.
	always_comb begin
		next_s = s;
		next_s.osc_q = guard_osc;
		next_s.sys_reset = do_reset;
		// Counter: held at zero when stopped, restarted by instruction or expiry.
		if (guard_restart || !running || expire) begin
			next_s.count = '0;
		end else if (tick) begin
			next_s.count = s.count + CNT_W'(1);
		end
		// Change window closes by itself.
		if (s.win != 3'h0) begin
			next_s.win = s.win - 3'h1;
		end
		// Bus handshake: one wait cycle, then the access completes.
		next_s.ack = (avs_read | avs_write) & ~s.ack;
		if ((avs_read | avs_write) && !s.ack) begin
			if (hit(avs_address, IDX_RESET_SOURCE_FLAGS)) begin
				next_s.rdata = {27'h0, s.reset_source_flags};
			end else if (hit(avs_address, IDX_GUARD_CONTROL_REG)) begin
				next_s.rdata = {24'h0, ctrl_view};
			end else if (hit(avs_address, IDX_SUPPLY_MONITOR_CONTROL)) begin
				next_s.rdata = {24'h0, s.supply_low_flag, s.supply_low_irq_enable, 5'h00,
					s.supply_monitor_on};
			end else begin
				next_s.rdata = 32'h0;
			end
		end
		if (wr_en && hit(avs_address, IDX_RESET_SOURCE_FLAGS)) begin
			// Writing zero clears a flag; writing one leaves it.
			next_s.reset_source_flags = s.reset_source_flags & wd[4:0];
		end else if (wr_en && hit(avs_address, IDX_GUARD_CONTROL_REG)) begin
			if (open_req) begin
				next_s.win = CHANGE_WIN_CYCLES;
				next_s.guard_reset_enable = 1'b1;
			end else if (s.win != 3'h0 && !wd[BIT_CHANGE_ENABLE]) begin
				next_s.guard_reset_enable = wd[BIT_RESET_ENABLE];
				next_s.guard_prescale = {wd[BIT_PRESCALE_HI], wd[2:0]};
				next_s.win = 3'h0;
			end else if (wd[BIT_RESET_ENABLE]) begin
				next_s.guard_reset_enable = 1'b1;
			end
			next_s.guard_irq_enable = wd[BIT_IRQ_ENABLE];
			if (wd[BIT_IRQ_FLAG]) begin
				next_s.guard_irq_flag = 1'b0;
			end
		end else if (wr_en && hit(avs_address, IDX_SUPPLY_MONITOR_CONTROL)) begin
			if (wd[BIT_SUPPLY_LOW_FLAG]) begin
				next_s.supply_low_flag = 1'b0;
			end
			next_s.supply_low_irq_enable = wd[BIT_SUPPLY_LOW_IE];
			next_s.supply_monitor_on = wd[BIT_SUPPLY_ON];
		end
		// Vectoring drops combined mode back to plain reset mode.
		if (guard_vector_ack) begin
			next_s.guard_irq_flag = 1'b0;
			next_s.guard_irq_enable = 1'b0;
		end
		// The fuse locks the interrupt enable low whatever software writes.
		if (guard_always_on_fuse) begin
			next_s.guard_irq_enable = 1'b0;
		end
		// A pending guard reset flag keeps reset enable from being cleared.
		if (next_s.reset_source_flags[BIT_GUARD_FLAG] || s.reset_source_flags[BIT_GUARD_FLAG]) begin
			next_s.guard_reset_enable = 1'b1;
		end
		// Hardware sets come last so an event beats a clear in the same cycle.
		if (do_irq) begin
			next_s.guard_irq_flag = 1'b1;
		end
		if (do_reset) begin
			next_s.reset_source_flags[BIT_GUARD_FLAG] = 1'b1;
			next_s.guard_reset_enable = 1'b1;
		end
		if (scan_reset_event) begin
			next_s.reset_source_flags[BIT_SCAN_FLAG] = 1'b1;
		end
		if (brownout_reset_event) begin
			next_s.reset_source_flags[BIT_BROWNOUT_FLAG] = 1'b1;
		end
		if (pin_reset_event) begin
			next_s.reset_source_flags[BIT_PIN_FLAG] = 1'b1;
		end
		// Supply comparator only counts while monitoring is switched on.
		if (supply_below && s.supply_monitor_on) begin
			next_s.supply_low_flag = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register; rstn is the power-on reset and sets only the power-on flag.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
			s.reset_source_flags <= RESET_FLAGS_INIT;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs. Interrupt requests are combinational so a sleeping core can wake
	// without waiting on the system clock path.
	assign avs_waitrequest = (avs_read | avs_write) & ~s.ack;
	assign avs_readdata = s.rdata;
	assign guard_irq = s.guard_irq_flag & s.guard_irq_enable & global_irq_enable;
	assign guard_sys_reset = s.sys_reset;
	assign supply_monitor_on = s.supply_monitor_on;
	assign supply_low_irq = s.supply_low_flag & s.supply_low_irq_enable
		& global_irq_enable;

	////////////////////////////////////////////////////////////////////////////
	// Checks on the block's own behaviour.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	sequence seq_window_open;
		(s.win == CHANGE_WIN_CYCLES) && !open_req;
	endsequence

	sequence seq_window_quiet;
		(!open_req)[*3];
	endsequence

	chk_change_autoclear: assert property (seq_window_open ##1 seq_window_quiet |=> s.win == 3'h0)
		else $error("Change enable did not clear four cycles after opening.");

	chk_prescale_locked: assert property (s.win == 3'h0 |=> s.guard_prescale == $past(s.guard_prescale))
		else $error("Prescale changed outside the change window.");

	chk_fuse_lock: assert property (guard_always_on_fuse && $past(guard_always_on_fuse)
		|-> !s.guard_irq_enable && ctrl_view[BIT_RESET_ENABLE])
		else $error("Always-on fuse did not lock the mode bits.");

	chk_reset_expiry: assert property (expire && eff_re && !eff_ie
		|=> s.sys_reset ##1 !s.sys_reset && s.reset_source_flags[BIT_GUARD_FLAG])
		else $error("Reset-mode expiry did not give a one-cycle reset and flag.");

	chk_irq_expiry: assert property (expire && eff_ie && !eff_re
		|=> s.guard_irq_flag && !s.sys_reset)
		else $error("Interrupt-mode expiry did not set the flag alone.");

	chk_combined_steps: assert property (expire && eff_ie && eff_re && !s.guard_irq_flag
		|=> s.guard_irq_flag && !s.sys_reset)
		else $error("Combined mode did not interrupt on first expiry.");

	chk_restart_zero: assert property (guard_restart |=> s.count == '0)
		else $error("Restart did not zero the counter.");

	chk_flag_holds_re: assert property (s.reset_source_flags[BIT_GUARD_FLAG]
		|-> ctrl_view[BIT_RESET_ENABLE] ##1 s.guard_reset_enable)
		else $error("Reset enable cleared while guard reset flag set.");

	chk_vector_clear: assert property (guard_vector_ack && !do_irq
		|=> !s.guard_irq_flag && !s.guard_irq_enable)
		else $error("Vectoring did not clear guard flag and enable.");

	chk_supply_set: assert property (supply_below && s.supply_monitor_on
		|=> s.supply_low_flag)
		else $error("Supply-low flag missed a low supply.");

	chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !(avs_read || avs_write) || !avs_waitrequest)
		else $error("Bus access waited more than one cycle.");

	////////////////////////////////////////////////////////////////////////////
	// Field, flag and counter checks. Each states the one-step effect of a rule,
	// so a failure points straight at the branch of next-state logic that broke.

	// A read of one register index in the cycle in which its data is captured.
	sequence seq_read_of(logic [7:0] idx);
		avs_read && !s.ack && hit(avs_address, idx);
	endsequence

	chk_status_upper: assert property (seq_read_of(IDX_RESET_SOURCE_FLAGS)
		|=> avs_readdata[31:5] == 27'h0)
		else $error("Upper reset-status bits did not read as zero.");

	chk_status_flags: assert property (seq_read_of(IDX_RESET_SOURCE_FLAGS)
		|=> avs_readdata[4:0] == $past(s.reset_source_flags))
		else $error("Reset-status read did not return the flags.");

	chk_reserved_zero: assert property (seq_read_of(IDX_SUPPLY_MONITOR_CONTROL)
		|=> avs_readdata[5:1] == 5'h00)
		else $error("Reserved supply monitor bits did not read as zero.");

	chk_poweron_sticky: assert property (s.reset_source_flags[BIT_POWERON_FLAG]
		&& !(wr_en && hit(avs_address, IDX_RESET_SOURCE_FLAGS))
		|=> s.reset_source_flags[BIT_POWERON_FLAG])
		else $error("Power-on flag cleared without a write.");

	chk_scan_set: assert property (scan_reset_event
		|=> s.reset_source_flags[BIT_SCAN_FLAG])
		else $error("Scan reset flag missed its event.");

	chk_brownout_set: assert property (brownout_reset_event
		|=> s.reset_source_flags[BIT_BROWNOUT_FLAG])
		else $error("Brown-out flag missed its event.");

	chk_pin_set: assert property (pin_reset_event
		|=> s.reset_source_flags[BIT_PIN_FLAG])
		else $error("Pin reset flag missed its event.");

	chk_guard_set: assert property (do_reset
		|=> s.reset_source_flags[BIT_GUARD_FLAG])
		else $error("Guard reset flag missed a guard reset.");

	chk_guard_clear: assert property (wr_en && hit(avs_address, IDX_RESET_SOURCE_FLAGS)
		&& !wd[BIT_GUARD_FLAG] && !do_reset |=> !s.reset_source_flags[BIT_GUARD_FLAG])
		else $error("Writing zero did not clear the guard reset flag.");

	chk_count_idle: assert property (!tick && !guard_restart && running
		|=> s.count == $past(s.count))
		else $error("Counter moved without an oscillator tick.");

	chk_count_step: assert property (tick && running && !guard_restart && !expire
		|=> s.count == $past(s.count) + CNT_W'(1))
		else $error("Counter did not advance on an oscillator tick.");

	chk_stopped_idle: assert property (!running
		|=> s.count == '0 && !s.sys_reset)
		else $error("Stopped timer counted or reset.");

	chk_expiry_acts: assert property (expire
		|=> s.sys_reset || s.guard_irq_flag)
		else $error("Expiry gave neither interrupt nor reset.");

	chk_expiry_zero: assert property (expire
		|=> s.count == '0)
		else $error("Counter did not restart after expiry.");

	chk_reset_pulse: assert property (s.sys_reset
		|=> !s.sys_reset)
		else $error("Guard reset pulse lasted more than one cycle.");

	chk_window_open: assert property (open_req
		|=> ctrl_view[BIT_CHANGE_ENABLE] && s.guard_reset_enable)
		else $error("Change window did not open.");

	chk_window_close: assert property (wr_en && hit(avs_address, IDX_GUARD_CONTROL_REG)
		&& s.win != 3'h0 && !wd[BIT_CHANGE_ENABLE] |=> !ctrl_view[BIT_CHANGE_ENABLE])
		else $error("Change window stayed open after the second write.");

	chk_re_locked: assert property (s.win == 3'h0 && s.guard_reset_enable
		|=> s.guard_reset_enable)
		else $error("Reset enable cleared outside the change window.");

	chk_re_set: assert property (wr_en && hit(avs_address, IDX_GUARD_CONTROL_REG)
		&& wd[BIT_RESET_ENABLE] |=> s.guard_reset_enable)
		else $error("Setting reset enable was refused.");

	chk_irq_clear: assert property (wr_en && hit(avs_address, IDX_GUARD_CONTROL_REG)
		&& wd[BIT_IRQ_FLAG] && !do_irq |=> !s.guard_irq_flag)
		else $error("Writing one did not clear the guard interrupt flag.");

	chk_supply_hold: assert property (s.supply_low_flag
		&& !(wr_en && hit(avs_address, IDX_SUPPLY_MONITOR_CONTROL) && wd[BIT_SUPPLY_LOW_FLAG])
		|=> s.supply_low_flag)
		else $error("Supply-low flag cleared without software.");

	chk_monitor_on: assert property (wr_en && hit(avs_address, IDX_SUPPLY_MONITOR_CONTROL)
		&& wd[BIT_SUPPLY_ON] |=> supply_monitor_on)
		else $error("Supply monitor did not switch on.");

	chk_monitor_off: assert property (wr_en && hit(avs_address, IDX_SUPPLY_MONITOR_CONTROL)
		&& !wd[BIT_SUPPLY_ON] |=> !supply_monitor_on)
		else $error("Supply monitor did not switch off.");

endmodule

// file: testbench/wrs_core_model.sv
/*
 * Processor core stand-in for the guard timer: sends restart pulses and
 * acknowledges the guard interrupt as the core does when it vectors to it.
 * Assumes everything runs on clk_sys and that the bench calls restart().
 */
`timescale 1ns/1ns
module wrs_core_model (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic guard_irq,
	input wire logic auto_vector,
	output logic guard_restart,
	output logic guard_vector_ack
);
	////////////////////////////////////////////////////////////////////////////////
	// The restart is idle from time zero so no stray restart lands in reset.
	initial begin
		guard_restart = 1'b0;
	end

	// One-cycle restart pulse, sent before the count runs out.
	task automatic restart();
		@(posedge clk_sys);
		guard_restart <= 1'b1;
		@(posedge clk_sys);
		guard_restart <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// The acknowledge lasts one cycle only, so the flag is cleared once per vector.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			guard_vector_ack <= 1'b0;
		end else begin
			guard_vector_ack <= auto_vector & guard_irq & ~guard_vector_ack;
		end
	end
endmodule

// file: testbench/tb_watchdog_reset_status.sv
/*
 * Self-checking bench for the guard timer and reset-status registers.
 * Assumes the design answers each register access within twenty cycles.
 */
`timescale 1ns/1ns
module tb_watchdog_reset_status import wrs_pkg::*;;
	logic clk_sys, rstn, avs_read, avs_write, avs_waitrequest, guard_osc, guard_fuse;
	logic global_irq_enable, scan_ev, brown_ev, pin_ev, supply_below, auto_vector;
	logic guard_restart, guard_vector_ack, guard_irq, guard_sys_reset, mon_on, low_irq;
	logic [ADDR_W-1:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	int bad_count = 0, samples_checked = 0, resets_seen = 0;

	wrs_guard #(.CNT_W(20)) i_wrs_guard (.clk_sys(clk_sys), .rstn(rstn),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_byteenable(4'hF), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .guard_osc(guard_osc),
		.guard_restart(guard_restart), .guard_vector_ack(guard_vector_ack),
		.guard_always_on_fuse(guard_fuse), .global_irq_enable(global_irq_enable),
		.scan_reset_event(scan_ev), .brownout_reset_event(brown_ev),
		.pin_reset_event(pin_ev), .supply_below(supply_below), .guard_irq(guard_irq),
		.guard_sys_reset(guard_sys_reset), .supply_monitor_on(mon_on),
		.supply_low_irq(low_irq));
	wrs_core_model i_wrs_core_model (.clk_sys(clk_sys), .rstn(rstn), .guard_irq(guard_irq),
		.auto_vector(auto_vector), .guard_restart(guard_restart),
		.guard_vector_ack(guard_vector_ack));

	////////////////////////////////////////////////////////////////////////////////
	// Clock and a tally of system reset pulses from the guard.
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (guard_sys_reset === 1'b1) begin
			resets_seen <= resets_seen + 1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Verdict and comparison helpers.
	task automatic summarize();
		$display("checked %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	// One Avalon access; the request stands until waitrequest is seen low at a rising edge,
	// and read data is taken at that same edge.
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [7:0] rd);
		int n;
		n = 0;
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h0, wd};
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge clk_sys);
			n++;
			if (n > 20) begin
				bad_count++;
				summarize();
			end
		end while (avs_waitrequest);
		rd = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] x;
		bus(1'b1, idx, d, x);
	endtask
	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] x;
		bus(1'b0, idx, 8'h00, x);
		check({24'h0, x}, {24'h0, exp}, "register read");
	endtask
	// Oscillator ticks slow enough for the design to see each rising edge.
	task automatic ticks(input int n);
		repeat (n) begin
			guard_osc <= 1'b1;
			repeat (2) @(posedge clk_sys);
			guard_osc <= 1'b0;
			repeat (2) @(posedge clk_sys);
		end
		repeat (8) @(posedge clk_sys);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic t_reset_flags();
		rd_chk(IDX_RESET_SOURCE_FLAGS, 8'h01);
		rd_chk(IDX_SUPPLY_MONITOR_CONTROL, 8'h00);
		rd_chk(IDX_GUARD_CONTROL_REG, 8'h00);
		wr(8'h10, 8'hFF);
		rd_chk(8'h10, 8'h00);
		scan_ev <= 1'b1;
		brown_ev <= 1'b1;
		pin_ev <= 1'b1;
		@(posedge clk_sys);
		{scan_ev, brown_ev, pin_ev} <= 3'h0;
		@(posedge clk_sys);
		rd_chk(IDX_RESET_SOURCE_FLAGS, 8'h17);
		wr(IDX_RESET_SOURCE_FLAGS, 8'hE0);
		rd_chk(IDX_RESET_SOURCE_FLAGS, 8'h00);
		$display("test reset flags done");
	endtask
	task automatic t_supply();
		wr(IDX_SUPPLY_MONITOR_CONTROL, 8'h41);
		supply_below <= 1'b1;
		repeat (4) @(posedge clk_sys);
		check({30'h0, mon_on, low_irq}, 32'h3, "supply irq");
		global_irq_enable <= 1'b0;
		@(posedge clk_sys);
		check({31'h0, low_irq}, 32'h0, "global mask");
		global_irq_enable <= 1'b1;
		rd_chk(IDX_SUPPLY_MONITOR_CONTROL, 8'hC1);
		wr(IDX_SUPPLY_MONITOR_CONTROL, 8'h01);
		check({31'h0, low_irq}, 32'h0, "supply mask");
		rd_chk(IDX_SUPPLY_MONITOR_CONTROL, 8'h81);
		supply_below <= 1'b0;
		wr(IDX_SUPPLY_MONITOR_CONTROL, 8'hBE);
		rd_chk(IDX_SUPPLY_MONITOR_CONTROL, 8'h00);
		check({31'h0, mon_on}, 32'h0, "monitor off");
		$display("test supply done");
	endtask
	task automatic t_irq_mode();
		wr(IDX_GUARD_CONTROL_REG, 8'h40);
		i_wrs_core_model.restart();
		ticks(1000);
		i_wrs_core_model.restart();
		ticks(2047);
		check({31'h0, guard_irq}, 32'h0, "restart early");
		ticks(1);
		check({31'h0, guard_irq}, 32'h1, "irq at timeout");
		check(resets_seen, 0, "no reset in irq mode");
		wr(IDX_GUARD_CONTROL_REG, 8'h80);
		rd_chk(IDX_GUARD_CONTROL_REG, 8'h00);
		$display("test irq mode done");
	endtask
	task automatic t_reset_modes();
		wr(IDX_GUARD_CONTROL_REG, 8'h08);
		i_wrs_core_model.restart();
		ticks(2048);
		check(resets_seen, 1, "reset mode expiry");
		rd_chk(IDX_RESET_SOURCE_FLAGS, 8'h08);
		wr(IDX_GUARD_CONTROL_REG, 8'h48);
		rd_chk(IDX_GUARD_CONTROL_REG, 8'h48);
		i_wrs_core_model.restart();
		ticks(2048);
		check({31'h0, guard_irq}, 32'h1, "combined first");
		auto_vector <= 1'b1;
		repeat (4) @(posedge clk_sys);
		auto_vector <= 1'b0;
		rd_chk(IDX_GUARD_CONTROL_REG, 8'h08);
		ticks(2048);
		check(resets_seen, 2, "combined second");
		$display("test reset modes done");
	endtask
	task automatic t_window();
		wr(IDX_RESET_SOURCE_FLAGS, 8'h00);
		wr(IDX_GUARD_CONTROL_REG, 8'h01);
		rd_chk(IDX_GUARD_CONTROL_REG, 8'h08);
		wr(IDX_GUARD_CONTROL_REG, 8'h18);
		wr(IDX_GUARD_CONTROL_REG, 8'h01);
		rd_chk(IDX_GUARD_CONTROL_REG, 8'h01);
		wr(IDX_GUARD_CONTROL_REG, 8'h18);
		repeat (6) @(posedge clk_sys);
		wr(IDX_GUARD_CONTROL_REG, 8'h00);
		rd_chk(IDX_GUARD_CONTROL_REG, 8'h09);
		wr(IDX_GUARD_CONTROL_REG, 8'h18);
		wr(IDX_GUARD_CONTROL_REG, 8'h41);
		i_wrs_core_model.restart();
		ticks(4095);
		check({31'h0, guard_irq}, 32'h0, "code one early");
		ticks(1);
		check({31'h0, guard_irq}, 32'h1, "code one expiry");
		wr(IDX_GUARD_CONTROL_REG, 8'h80);
		guard_fuse <= 1'b1;
		wr(IDX_GUARD_CONTROL_REG, 8'h41);
		rd_chk(IDX_GUARD_CONTROL_REG, 8'h09);
		guard_fuse <= 1'b0;
		$display("test window and fuse done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset for twelve cycles, then every scenario in turn.
	initial begin
		rstn = 1'b0;
		{avs_read, avs_write, guard_osc, guard_fuse, scan_ev, brown_ev, pin_ev} = 7'h00;
		{supply_below, auto_vector} = 2'h0;
		global_irq_enable = 1'b1;
		avs_address = '0;
		avs_writedata = 32'h0;
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		t_reset_flags();
		t_supply();
		t_irq_mode();
		t_reset_modes();
		t_window();
		summarize();
	end
endmodule
